// file: design/selftest_pkg.sv
// Constants and types shared by the self-test sequencer and its testbench
`default_nettype none
package selftest_pkg;
	// ************************************************
	// Timing
	// ************************************************
	localparam int CLK_KHZ = 100000;
	localparam int DISPLAY_MS = 500;
	localparam int DISP_CYCLES = CLK_KHZ * DISPLAY_MS;
	localparam int BAUD_300 = 300;
	localparam int BAUD_2400 = 2400;
	localparam int BAUD_9600 = 9600;
	localparam int BIT_300_CYCLES = CLK_KHZ * 1000 / BAUD_300;
	localparam int BIT_2400_CYCLES = CLK_KHZ * 1000 / BAUD_2400;
	localparam int BIT_9600_CYCLES = CLK_KHZ * 1000 / BAUD_9600;
	localparam int RAMP_STEP_US = 2;
	localparam int RAMP_STEP_CYCLES = (RAMP_STEP_US * CLK_KHZ + 999) / 1000;
	localparam int STRAP_WAIT = 3;
	localparam int CNT_W = 26;

	// ************************************************
	// Patterns and frame layout
	// ************************************************
	localparam logic [7:0] RAM_PAT_A = 8'h55;
	localparam logic [7:0] RAM_PAT_B = 8'haa;
	localparam logic [7:0] LOOP_BYTE = 8'ha5;
	localparam logic [3:0] FRAME_LAST = 4'h9;
	localparam logic [1:0] RATE_LAST = 2'h2;
	localparam logic [1:0] PH_ISSUE = 2'h0;
	localparam logic [1:0] PH_CHECK = 2'h2;

	// ************************************************
	// Synchronised input positions
	// ************************************************
	localparam int IN_CLR = 0;
	localparam int IN_7 = 1;
	localparam int IN_RAMP = 2;
	localparam int IN_LOOP = 3;
	localparam int IN_LOW = 4;
	localparam int IN_WD = 5;
	localparam int IN_RX = 6;
	localparam int IN_N = 7;

	// ************************************************
	// Display codes
	// ************************************************
	typedef enum logic [2:0] {
		UP_BLANK = 3'h0,
		UP_PWR = 3'h1,
		UP_WDOG = 3'h2,
		UP_PROM = 3'h3,
		UP_RAM = 3'h5
	} upper_code_t;

	typedef enum logic [2:0] {
		LO_BLANK = 3'h0,
		LO_PASS = 3'h1,
		LO_ERR = 3'h2,
		LO_F300 = 3'h3,
		LO_F2400 = 3'h4,
		LO_F9600 = 3'h5
	} lower_code_t;
endpackage
`default_nettype wire

// file: design/ram_port_if.sv
// Port bundle between the sequencer and the scratch memory under test
`default_nettype none
interface ram_port_if #(parameter int AW = 8, parameter int DW = 8);
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic we;
	logic [DW-1:0] rdata;
	modport ctl (output addr, output wdata, output we, input rdata);
	modport mem (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// file: design/ram_pattern_mem.sv
// Scratch memory exercised by the power-up pattern test
`default_nettype none
module ram_pattern_mem #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	// Clock
	input wire logic sys_clk,
	// Access port
	ram_port_if.mem port
);
	logic [DW-1:0] cells [2**AW];

	// Write port and registered read data
	always_ff @(posedge sys_clk)
	begin
		if (port.we)
		begin
			cells[port.addr] <= port.wdata;
		end
		port.rdata <= cells[port.addr];
	end
endmodule
`default_nettype wire

// file: design/diagnostic_selftest_sequencer.sv
// Power-up memory tests, fault codes and operator diagnostic tests 9 and 10
`default_nettype none
// How it works
// - Ramp test sweeps the speed command from full positive to full negative and back.
// - Loopback passing at all three rates shows the pass code below.
// - Each failing rate briefly shows its own code: 03, 24 or 96.
// - After the loopback test, any failure briefly shows the error code below.
// - The loopback test returns to normal operation without a key press.
// - Every power-up runs two self-tests before normal operation.
// - First test writes patterns into RAM and reads them back to compare.
// - RAM failure halts, shows code 5 above, continues on the clear key.
// - A passing RAM test goes straight to the program memory test.
// - Program memory test sums all words and compares with the expected sum.
// - Checksum mismatch stops, shows code 3 above until clear is pressed.
// - Passing checksum starts initialization and normal operation on its own.
// - Line undervoltage shows power-failure code 1 above unless a watchdog timeout has been seen since reset.
// - A watchdog timeout shows code 2 above.
// - Clear plus 7 held at power-up restores defaults, then runs power-up tests.
module diagnostic_selftest_sequencer
	import selftest_pkg::*;
#(
	parameter int RAM_AW = 8,
	parameter int PROM_AW = 12,
	parameter int DAC_W = 12,
	parameter logic [15:0] PROM_SUM = 16'h0000,
	parameter int DISP_LEN = selftest_pkg::DISP_CYCLES,
	parameter int BIT_300 = selftest_pkg::BIT_300_CYCLES,
	parameter int BIT_2400 = selftest_pkg::BIT_2400_CYCLES,
	parameter int BIT_9600 = selftest_pkg::BIT_9600_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Keypad and operator test starts
	input wire logic key_clear,
	input wire logic key_7,
	input wire logic ramp_go,
	input wire logic loop_go,
	// Fault monitors
	input wire logic line_low,
	input wire logic wdog_timeout,
	// Serial loopback pins
	input wire logic rx_pin,
	output logic tx_pin,
	// Program memory
	output logic [PROM_AW-1:0] rom_addr,
	input wire logic [7:0] rom_data,
	// Speed command and displays
	output logic [DAC_W-1:0] dac_code,
	output selftest_pkg::upper_code_t upper_code,
	output selftest_pkg::lower_code_t lower_code,
	// Sequence status
	output logic defaults_restore,
	output logic init_start,
	output logic normal_run
);
	import selftest_pkg::*;

	localparam logic [DAC_W-1:0] DAC_MAX = {DAC_W{1'b1}};
	localparam logic [DAC_W-1:0] DAC_MIN = {DAC_W{1'b0}};
	localparam logic [DAC_W-1:0] DAC_MID = {1'b1, {(DAC_W-1){1'b0}}};
	localparam logic [CNT_W-1:0] DISP_LAST = CNT_W'(DISP_LEN - 1);
	localparam logic [CNT_W-1:0] RAMP_LAST = CNT_W'(RAMP_STEP_CYCLES - 1);
	localparam logic [RAM_AW-1:0] RAM_END = {RAM_AW{1'b1}};
	localparam logic [PROM_AW-1:0] PROM_END = {PROM_AW{1'b1}};
	localparam logic [9:0] FRAME = {1'b1, LOOP_BYTE, 1'b0};

	// ************************************************
	// Parameter checks
	// ************************************************
	if (DISP_LEN < 8 || DISP_LEN > 2**CNT_W || BIT_300 > 2**CNT_W || BIT_9600 < 8 || DAC_W < 2
		|| RAM_AW < 1 || PROM_AW < 1 || RAM_AW > PROM_AW)
	begin : g_bad_param
		$error("Self-test sequencer parameters out of range");
	end

	// ************************************************
	// State
	// ************************************************
	typedef enum logic [10:0] {
		ST_STRAP = 11'h001,
		ST_RAM_WR = 11'h002,
		ST_RAM_RD = 11'h004,
		ST_RAM_FAIL = 11'h008,
		ST_PROM = 11'h010,
		ST_PROM_FAIL = 11'h020,
		ST_RUN = 11'h040,
		ST_RAMP = 11'h080,
		ST_LOOP = 11'h100,
		ST_LOOP_SHOW = 11'h200,
		ST_LOOP_END = 11'h400
	} seq_state_t;

	typedef struct packed {
		logic [IN_N-1:0] sync1;
		logic [IN_N-1:0] sync2;
		logic [IN_N-1:0] prev;
		seq_state_t state;
		logic [CNT_W-1:0] cnt;
		logic [PROM_AW-1:0] addr;
		logic [1:0] phase;
		logic pat;
		logic [15:0] sum;
		logic [1:0] rate;
		logic [3:0] bitn;
		logic [9:0] rxsh;
		logic [2:0] fails;
		logic [DAC_W-1:0] dac;
		logic dac_up;
		logic tx;
		logic wdog_seen;
		logic [RAM_AW-1:0] ram_addr;
		logic [7:0] ram_wdata;
		logic ram_we;
		logic [PROM_AW-1:0] rom_addr;
		upper_code_t upper;
		lower_code_t lower;
		logic defaults_restore;
		logic init_start;
		logic normal_run;
	} seq_t;

	seq_t s;
	seq_t next_s;
	logic adv;
	logic clr_edge;
	logic [7:0] ram_expect;
	ram_port_if #(.AW(RAM_AW), .DW(8)) ram_bus ();

	// Bit period of a loopback rate in clock cycles
	function automatic logic [CNT_W-1:0] bit_period(input logic [1:0] r);
		unique case (r)
			2'h0: bit_period = CNT_W'(BIT_300);
			2'h1: bit_period = CNT_W'(BIT_2400);
			default: bit_period = CNT_W'(BIT_9600);
		endcase
	endfunction

	// Lower display code for a failing rate
	function automatic lower_code_t rate_code(input logic [1:0] r);
		unique case (r)
			2'h0: rate_code = LO_F300;
			2'h1: rate_code = LO_F2400;
			default: rate_code = LO_F9600;
		endcase
	endfunction

	// Memory under test
	ram_pattern_mem #(.AW(RAM_AW), .DW(8)) u_mem (
		.sys_clk(sys_clk),
		.port(ram_bus.mem)
	);

	// Drive the memory port from registered fields
	assign ram_bus.addr = s.ram_addr;
	assign ram_bus.wdata = s.ram_wdata;
	assign ram_bus.we = s.ram_we;
	assign clr_edge = s.sync2[IN_CLR] & ~s.prev[IN_CLR];
	assign ram_expect = (s.pat ? RAM_PAT_B : RAM_PAT_A) ^ 8'(s.addr);

	// ************************************************
	// Next state
	// ************************************************
	always_comb
	begin
		next_s = s;
		adv = 1'b0;
		next_s.sync1 = {rx_pin, wdog_timeout, line_low, loop_go, ramp_go, key_7, key_clear};
		next_s.sync2 = s.sync1;
		next_s.prev = s.sync2;
		next_s.ram_we = 1'b0;
		next_s.defaults_restore = 1'b0;
		next_s.init_start = 1'b0;
		if (s.sync2[IN_WD])
		begin
			next_s.wdog_seen = 1'b1;
		end
		unique case (s.state)
			ST_STRAP:
			begin
				next_s.cnt = s.cnt + 1'b1;
				if (s.cnt == CNT_W'(STRAP_WAIT))
				begin
					next_s.cnt = '0;
					next_s.addr = '0;
					next_s.pat = 1'b0;
					next_s.state = ST_RAM_WR;
					next_s.defaults_restore = s.sync2[IN_CLR] & s.sync2[IN_7];
				end
			end
			ST_RAM_WR:
			begin
				next_s.ram_we = 1'b1;
				next_s.ram_addr = RAM_AW'(s.addr);
				next_s.ram_wdata = ram_expect;
				next_s.addr = s.addr + 1'b1;
				if (RAM_AW'(s.addr) == RAM_END)
				begin
					next_s.addr = '0;
					next_s.phase = PH_ISSUE;
					next_s.state = ST_RAM_RD;
				end
			end
			ST_RAM_RD:
			begin
				next_s.ram_addr = RAM_AW'(s.addr);
				next_s.phase = s.phase + 1'b1;
				if (s.phase == PH_CHECK)
				begin
					next_s.phase = PH_ISSUE;
					next_s.addr = s.addr + 1'b1;
					if (ram_bus.rdata != ram_expect)
					begin
						next_s.state = ST_RAM_FAIL;
					end
					else if (RAM_AW'(s.addr) == RAM_END)
					begin
						next_s.addr = '0;
						next_s.pat = 1'b1;
						next_s.sum = '0;
						next_s.state = s.pat ? ST_PROM : ST_RAM_WR;
					end
				end
			end
			ST_RAM_FAIL:
			begin
				if (clr_edge)
				begin
					next_s.addr = '0;
					next_s.sum = '0;
					next_s.phase = PH_ISSUE;
					next_s.state = ST_PROM;
				end
			end
			ST_PROM:
			begin
				next_s.rom_addr = s.addr;
				next_s.phase = s.phase + 1'b1;
				if (s.phase == PH_CHECK)
				begin
					next_s.phase = PH_ISSUE;
					next_s.addr = s.addr + 1'b1;
					next_s.sum = s.sum + 16'(rom_data);
					if (s.addr == PROM_END)
					begin
						if (next_s.sum == PROM_SUM)
						begin
							next_s.init_start = 1'b1;
							next_s.state = ST_RUN;
						end
						else
						begin
							next_s.state = ST_PROM_FAIL;
						end
					end
				end
			end
			ST_PROM_FAIL:
			begin
				if (clr_edge)
				begin
					next_s.init_start = 1'b1;
					next_s.state = ST_RUN;
				end
			end
			ST_RUN:
			begin
				if (s.sync2[IN_RAMP] & ~s.prev[IN_RAMP])
				begin
					next_s.dac = DAC_MAX;
					next_s.dac_up = 1'b0;
					next_s.cnt = '0;
					next_s.state = ST_RAMP;
				end
				else if (s.sync2[IN_LOOP] & ~s.prev[IN_LOOP])
				begin
					next_s.rate = '0;
					next_s.fails = '0;
					next_s.bitn = '0;
					next_s.cnt = '0;
					next_s.tx = FRAME[0];
					next_s.lower = LO_BLANK;
					next_s.state = ST_LOOP;
				end
			end
			ST_RAMP:
			begin
				next_s.cnt = s.cnt + 1'b1;
				if (clr_edge)
				begin
					next_s.dac = DAC_MID;
					next_s.state = ST_RUN;
				end
				else if (s.cnt == RAMP_LAST)
				begin
					next_s.cnt = '0;
					if (s.dac_up)
					begin
						next_s.dac = (s.dac == DAC_MAX) ? s.dac : s.dac + 1'b1;
						next_s.dac_up = (s.dac != DAC_MAX);
					end
					else
					begin
						next_s.dac = (s.dac == DAC_MIN) ? s.dac : s.dac - 1'b1;
						next_s.dac_up = (s.dac == DAC_MIN);
					end
				end
			end
			ST_LOOP:
			begin
				next_s.cnt = s.cnt + 1'b1;
				if (s.cnt == (bit_period(s.rate) >> 1))
				begin
					next_s.rxsh = {s.sync2[IN_RX], s.rxsh[9:1]};
				end
				if (s.cnt == bit_period(s.rate) - 1'b1)
				begin
					next_s.cnt = '0;
					next_s.bitn = s.bitn + 1'b1;
					next_s.tx = FRAME[4'(s.bitn + 1'b1)];
					if (s.bitn == FRAME_LAST)
					begin
						next_s.tx = 1'b1;
						if (s.rxsh != FRAME)
						begin
							next_s.fails[s.rate] = 1'b1;
							next_s.lower = rate_code(s.rate);
							next_s.state = ST_LOOP_SHOW;
						end
						else
						begin
							adv = 1'b1;
						end
					end
				end
			end
			ST_LOOP_SHOW:
			begin
				next_s.cnt = s.cnt + 1'b1;
				if (s.cnt == DISP_LAST)
				begin
					next_s.lower = LO_BLANK;
					adv = 1'b1;
				end
			end
			ST_LOOP_END:
			begin
				next_s.cnt = s.cnt + 1'b1;
				if (s.cnt == DISP_LAST)
				begin
					next_s.lower = LO_BLANK;
					next_s.state = ST_RUN;
				end
			end
		endcase
		// Move to the next rate or finish the loopback test
		if (adv)
		begin
			next_s.cnt = '0;
			next_s.bitn = '0;
			if (s.rate == RATE_LAST)
			begin
				next_s.lower = (next_s.fails != '0) ? LO_ERR : LO_PASS;
				next_s.state = (next_s.fails != '0) ? ST_LOOP_END : ST_RUN;
			end
			else
			begin
				next_s.rate = s.rate + 1'b1;
				next_s.tx = FRAME[0];
				next_s.state = ST_LOOP;
			end
		end
		// Upper display, watchdog over power fail over test codes
		if (next_s.wdog_seen)
			next_s.upper = UP_WDOG;
		else if (next_s.sync2[IN_LOW])
			next_s.upper = UP_PWR;
		else if (next_s.state == ST_RAM_FAIL)
			next_s.upper = UP_RAM;
		else if (next_s.state == ST_PROM_FAIL)
			next_s.upper = UP_PROM;
		else
			next_s.upper = UP_BLANK;
		next_s.normal_run = (next_s.state == ST_RUN) || (next_s.state == ST_RAMP)
			|| (next_s.state == ST_LOOP) || (next_s.state == ST_LOOP_SHOW) || (next_s.state == ST_LOOP_END);
	end

	// State register
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			s <= '0;
			s.state <= ST_STRAP;
			s.tx <= 1'b1;
			s.dac <= DAC_MID;
		end
		else
		begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign tx_pin = s.tx;
	assign rom_addr = s.rom_addr;
	assign dac_code = s.dac;
	assign upper_code = s.upper;
	assign lower_code = s.lower;
	assign defaults_restore = s.defaults_restore;
	assign init_start = s.init_start;
	assign normal_run = s.normal_run;

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	a_ramp_turn_up: assert property (s.state == ST_RAMP && !s.dac_up && s.dac == DAC_MIN && s.cnt == RAMP_LAST
		&& !clr_edge |=> s.dac_up && s.dac == DAC_MIN)
		else $error("ramp did not turn at negative full scale");
	a_loop_pass: assert property ($past(s.state) == ST_LOOP && s.state == ST_RUN |-> s.lower == LO_PASS)
		else $error("loopback pass without pass code");
	a_rate_code: assert property (s.state == ST_LOOP_SHOW |-> s.lower == rate_code(s.rate) && s.fails[s.rate])
		else $error("wrong rate failure code");
	a_err_summary: assert property (s.state == ST_LOOP_END |-> s.lower == LO_ERR && s.fails != '0)
		else $error("error summary wrong");
	a_loop_leave: assert property (s.state == ST_LOOP_END && s.cnt == DISP_LAST |=> s.state == ST_RUN)
		else $error("loopback test did not exit");
	a_no_run_early: assert property (s.state inside {ST_RAM_WR, ST_RAM_RD, ST_PROM} |-> !s.normal_run)
		else $error("normal operation before self-test");
	a_ram_write: assert property (s.state == ST_RAM_WR |=> s.ram_we)
		else $error("pattern write missing");
	a_ram_halt: assert property (s.state == ST_RAM_FAIL && !clr_edge |=> s.state == ST_RAM_FAIL)
		else $error("RAM failure did not halt");
	a_ram_to_prom: assert property (s.state == ST_RAM_RD && s.phase == PH_CHECK && s.pat
		&& RAM_AW'(s.addr) == RAM_END && ram_bus.rdata == ram_expect |=> s.state == ST_PROM)
		else $error("RAM pass did not start checksum");
	a_prom_halt: assert property (s.state == ST_PROM_FAIL && !clr_edge |=> s.state == ST_PROM_FAIL)
		else $error("checksum failure did not halt");
	a_prom_exit: assert property ($past(s.state) == ST_PROM && s.state == ST_RUN |-> s.init_start
		&& $past(s.sum, 1) + 16'($past(rom_data)) == PROM_SUM)
		else $error("checksum exit wrong");
	a_pwr_code: assert property (s.sync2[IN_LOW] && !s.wdog_seen |-> s.upper == UP_PWR)
		else $error("power failure code missing");
	a_wdog_code: assert property (s.sync2[IN_WD] |=> s.upper == UP_WDOG [*3])
		else $error("watchdog code missing");
	a_strap_restore: assert property (s.defaults_restore |-> s.state == ST_RAM_WR && s.addr == '0)
		else $error("defaults restore out of sequence");
	a_show_hold: assert property ($rose(s.state == ST_LOOP_SHOW) |-> (s.state == ST_LOOP_SHOW) [*8])
		else $error("failure code not held");
	a_bad_frame: assert property (s.state == ST_LOOP && s.bitn == FRAME_LAST
		&& s.cnt == bit_period(s.rate) - 1'b1 && s.rxsh != FRAME |=> s.state == ST_LOOP_SHOW)
		else $error("bad loopback frame not failed");

	c_powerup_pass: cover property (s.state == ST_PROM ##1 s.state == ST_RUN);
	c_loop_fail: cover property (s.state == ST_LOOP_END);
	c_ram_fail: cover property (s.state == ST_RAM_FAIL ##1 clr_edge);
	c_ramp_turn: cover property (s.state == ST_RAMP && s.dac_up);
endmodule
`default_nettype wire

// file: test/selftest_panel_model.sv
// Far-side model: loopback jumper on the serial pins and the program memory
`default_nettype none
module selftest_panel_model #(
	parameter int AW = 4
) (
	// Clock
	input wire logic sys_clk,
	// Loopback jumper
	input wire logic tx_pin,
	input wire logic [1:0] loop_mode,
	output logic rx_pin,
	// Program memory
	input wire logic [AW-1:0] rom_addr,
	input wire logic rom_bad,
	output logic [7:0] rom_data
);
	timeunit 1ns;
	timeprecision 1ps;

	// Jumper: straight, open line idling high, or inverting
	always_comb
	begin
		case (loop_mode)
			2'h1: rx_pin = 1'b1;
			2'h2: rx_pin = ~tx_pin;
			default: rx_pin = tx_pin;
		endcase
	end

	// Synchronous memory, data one cycle after the address; one bit may be spoiled
	always_ff @(posedge sys_clk)
	begin
		rom_data <= (8'(rom_addr) * 8'h11) ^ {7'h00, rom_bad && (rom_addr == '0)};
	end
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the power-up and diagnostic self-test sequencer
`default_nettype none
`define CHECK(name, exp, got) begin compares++; if ((got) !== (exp)) begin fail_count++; \
	$display("unexpected %s expected %h seen %h", name, exp, got); end end
module tb_top;
	import selftest_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************
	// Signals and shortened counts
	// ************************************************
	localparam int DISP = 20;
	localparam int NARROW = 4; // Address and converter width of the shortened build
	localparam logic [15:0] ROM_SUM = 16'h07f8; // Sum of 8'h11 * a over a = 0..15
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic key_clear = 1'b0;
	logic key_7 = 1'b0;
	logic ramp_go = 1'b0;
	logic loop_go = 1'b0;
	logic line_low = 1'b0;
	logic wdog_timeout = 1'b0;
	logic rx_pin;
	logic tx_pin;
	logic [3:0] rom_addr;
	logic [7:0] rom_data;
	logic [3:0] dac_code;
	upper_code_t upper_code;
	lower_code_t lower_code;
	logic defaults_restore;
	logic init_start;
	logic normal_run;
	logic [1:0] loop_mode = 2'h0;
	logic rom_bad = 1'b0;
	int fail_count = 0;
	int compares = 0;
	int hold = 0;
	logic [7:0] exp_q[$];
	upper_code_t prev_up;
	lower_code_t prev_lo;
	logic [3:0] prev_dac;

	always #5 sys_clk = ~sys_clk;

	diagnostic_selftest_sequencer #(.RAM_AW(NARROW), .PROM_AW(NARROW), .DAC_W(NARROW), .PROM_SUM(ROM_SUM),
		.DISP_LEN(DISP),
		.BIT_300(40), .BIT_2400(24), .BIT_9600(16)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.key_clear(key_clear), .key_7(key_7), .ramp_go(ramp_go), .loop_go(loop_go), .line_low(line_low),
		.wdog_timeout(wdog_timeout), .rx_pin(rx_pin), .tx_pin(tx_pin), .rom_addr(rom_addr),
		.rom_data(rom_data), .dac_code(dac_code), .upper_code(upper_code), .lower_code(lower_code),
		.defaults_restore(defaults_restore), .init_start(init_start), .normal_run(normal_run));

	selftest_panel_model panel_u (.sys_clk(sys_clk), .tx_pin(tx_pin), .loop_mode(loop_mode),
		.rx_pin(rx_pin), .rom_addr(rom_addr), .rom_bad(rom_bad), .rom_data(rom_data));

	// ************************************************
	// Expectation queue and result watcher
	// ************************************************
	task automatic expect_ev(input logic [3:0] k, input logic [3:0] c);
		exp_q.push_back({k, c});
	endtask

	task automatic note(input logic [3:0] k, input logic [3:0] c);
		logic [7:0] e;
		if (exp_q.size() == 0)
		begin
			fail_count++;
			$display("unexpected event expected none seen %h", {k, c});
		end
		else
		begin
			e = exp_q.pop_front();
			`CHECK("event", e, {k, c})
		end
	endtask

	// Turns display changes, pulses and ramp extremes into events
	always @(posedge sys_clk)
	begin
		if (sys_rst === 1'b0)
		begin
			if (upper_code !== prev_up && upper_code !== UP_BLANK) note(4'h1, {1'b0, upper_code});
			if (lower_code !== prev_lo && lower_code !== LO_BLANK) note(4'h2, {1'b0, lower_code});
			if (lower_code !== prev_lo && prev_lo inside {LO_ERR, LO_F300, LO_F2400, LO_F9600})
				`CHECK("code hold", DISP, hold)
			if (init_start === 1'b1) note(4'h3, 4'h0);
			if (defaults_restore === 1'b1) note(4'h4, 4'h0);
			if (dac_code !== prev_dac && dac_code === 4'hf) note(4'h5, 4'h1);
			if (dac_code !== prev_dac && dac_code === 4'h0) note(4'h5, 4'h2);
		end
		hold = (lower_code === prev_lo) ? hold + 1 : 1;
		prev_up = upper_code;
		prev_lo = lower_code;
		prev_dac = dac_code;
	end

	// ************************************************
	// Driver tasks
	// ************************************************
	task automatic drain(input int lim);
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < lim)
		begin
			@(posedge sys_clk);
			n++;
		end
		if (exp_q.size() != 0)
		begin
			fail_count++;
			$display("unexpected wait expected %0d events seen none", exp_q.size());
			exp_q.delete();
		end
		repeat (30) @(posedge sys_clk);
	endtask

	// Key 0 clear, 1 ramp start, 2 loopback start
	task automatic press(input int which);
		case (which)
			0: key_clear <= 1'b1;
			1: ramp_go <= 1'b1;
			default: loop_go <= 1'b1;
		endcase
		repeat ($urandom_range(8, 4)) @(posedge sys_clk);
		key_clear <= 1'b0;
		ramp_go <= 1'b0;
		loop_go <= 1'b0;
		repeat ($urandom_range(12, 6)) @(posedge sys_clk);
	endtask

	task automatic do_reset(input logic c7, input logic bad);
		int n;
		sys_rst <= 1'b1;
		key_clear <= c7;
		key_7 <= c7;
		rom_bad <= bad;
		repeat (12) @(posedge sys_clk);
		if (c7) expect_ev(4'h4, 4'h0);
		if (bad) expect_ev(4'h1, 4'h3);
		expect_ev(4'h3, 4'h0);
		sys_rst <= 1'b0;
		repeat (10) @(posedge sys_clk);
		key_clear <= 1'b0;
		key_7 <= 1'b0;
		`CHECK("normal_run", 1'b0, normal_run)
		if (bad)
		begin
			for (n = 0; n < 2000 && upper_code !== UP_PROM; n++) @(posedge sys_clk);
			repeat (20) @(posedge sys_clk);
			`CHECK("normal_run", 1'b0, normal_run)
			press(0);
		end
		drain(2000);
		`CHECK("normal_run", 1'b1, normal_run)
		rom_bad <= 1'b0;
	endtask

	task automatic end_of_test();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ************************************************
	// Main sequence and watchdog
	// ************************************************
	initial
	begin
		int n;
		void'($urandom(20));
		do_reset(1'b1, 1'b0);
		// No byte at any rate
		loop_mode <= 2'h1;
		expect_ev(4'h2, {1'b0, LO_F300});
		expect_ev(4'h2, {1'b0, LO_F2400});
		expect_ev(4'h2, {1'b0, LO_F9600});
		expect_ev(4'h2, {1'b0, LO_ERR});
		press(2);
		drain(4000);
		// Wrong byte at the first rate only
		loop_mode <= 2'h2;
		expect_ev(4'h2, {1'b0, LO_F300});
		expect_ev(4'h2, {1'b0, LO_ERR});
		press(2);
		for (n = 0; n < 2000 && lower_code !== LO_F300; n++) @(posedge sys_clk);
		loop_mode <= 2'h0;
		drain(4000);
		// All rates good, then ramp swept to both ends and left with the clear key
		expect_ev(4'h2, {1'b0, LO_PASS});
		press(2);
		drain(4000);
		expect_ev(4'h5, 4'h1);
		expect_ev(4'h5, 4'h2);
		expect_ev(4'h5, 4'h1);
		press(1);
		drain(8000);
		press(0);
		do_reset(1'b0, 1'b1);
		// Fault monitors
		expect_ev(4'h1, {1'b0, UP_PWR});
		line_low <= 1'b1;
		drain(100);
		line_low <= 1'b0;
		repeat (10) @(posedge sys_clk);
		expect_ev(4'h1, {1'b0, UP_WDOG});
		wdog_timeout <= 1'b1;
		drain(100);
		line_low <= 1'b1;
		repeat (10) @(posedge sys_clk);
		`CHECK("upper_code", UP_WDOG, upper_code)
		end_of_test();
	end

	initial
	begin
		#800us;
		fail_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
